// >>> design/frontend_test_pkg.sv
// package: offsets, field layout and reset values of the front end test override register
//
// Functional notes
// - bit 22 low enables the fs/ls line driver, high tri-states it; resets 0.
// - bit 21 gives the fs/ls value driven onto the plus line.
// - bit 20 gives the fs/ls value driven onto the minus line.
// - bit 19 is read-only, shows the differential receiver output; resets 0.
// - bits 15:14 hs transmit valid mask: 00 none, 01 low, 11 both; 10 invalid.
// - bits 13:12 hold two hs transmit bits, sent low bit first.
// - bit 11 powers hs current source; forced on while port is high-speed.
// - bits 10:8 trim hs drive current, eight documented steps, 000 nominal.
// - trim field survives protected resets; hresetn reloads its default, otherwise only its reload events and bus writes change it.
// - bit 7 enables 1.5k pull-up on the plus line; resets 0.
// - bit 6 enables the 1.5k pull-up named for the minus line; resets 0.
// - bit 5 enables 15k pull-down on the plus line; resets 0.
// - bit 4 enables 15k pull-down on the minus line; resets 0.
// - bit 1: 0 hs driver low power at idle, 1 active transmit, source on.
// - trim default: config image if present, else programmed otp, else 000.
// - usb or lite reset reloads trim from config image, else 000.
package frontend_test_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  OVERRIDE_OFFSET = 8'hC4;
  localparam logic [31:0] OVERRIDE_RESET  = 32'h0000_0000;
  localparam logic [31:0] WRITE_MASK      = 32'h0070_FFF2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FS_OEN_BIT   = 22;
  localparam int FS_VP_BIT    = 21;
  localparam int FS_VM_BIT    = 20;
  localparam int FS_RX_BIT    = 19;
  localparam int TXVAL_LSB    = 14;
  localparam int TXDAT_LSB    = 12;
  localparam int HS_CS_BIT    = 11;
  localparam int TRIM_LSB     = 8;
  localparam int PU_DP_BIT    = 7;
  localparam int PU_DM_BIT    = 6;
  localparam int PD_DP_BIT    = 5;
  localparam int PD_DM_BIT    = 4;
  localparam int TXACT_BIT    = 1;

  localparam logic [2:0] TRIM_NOMINAL  = 3'h0;
  localparam logic [1:0] MASK_INVALID  = 2'h2;
  localparam logic [1:0] MASK_NONE     = 2'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       fs_driver_enable_n;
    logic       fs_positive_line_out;
    logic       fs_negative_line_out;
    logic [1:0] frontend_hs_tx_valid_bus;
    logic [1:0] hs_tx_bits;
    logic       hs_current_source_on;
    logic [2:0] hs_drive_current_trim;
    logic       pullup_plus_line_on;
    logic       pullup_minus_line_on;
    logic       pulldown_plus_line_on;
    logic       pulldown_minus_line_on;
    logic       hs_driver_transmit_active;
  } frontend_ctrl_t;

  typedef struct packed {
    logic       image_present;
    logic [2:0] config_image_current_trim;
    logic       otp_programmed;
    logic [2:0] otp_current_trim;
  } trim_source_t;

endpackage : frontend_test_pkg

// >>> design/usb_frontend_test_override.sv
// module: ahb-lite slave holding the usb front end test override register
`timescale 1ns/1ps
module usb_frontend_test_override
  import frontend_test_pkg::*;
(
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic [31:0]         hrdata,
  output logic                hreadyout,
  output logic                hresp,
  input  wire logic           fs_diff_receiver_in,
  input  wire logic           hs_mode,
  input  wire logic           usb_reset,
  input  wire logic           lite_reset,
  input  wire trim_source_t   trim_source,
  output frontend_ctrl_t      frontend_ctrl,
  output logic                hs_mask_invalid
);

  // ----------------------------------------------------------------
  // pin synchroniser for the receiver output
  // ----------------------------------------------------------------
  logic rx_meta_r;
  logic rx_sync_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_meta_r <= 1'b0;
      rx_sync_r <= 1'b0;
    end
    else
    begin
      rx_meta_r <= fs_diff_receiver_in;
      rx_sync_r <= rx_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite address phase capture
  // ----------------------------------------------------------------
  logic       wr_pend_r;
  logic       rd_hit_r;
  logic       wr_hit_r;
  wire  logic addr_valid;
  wire  logic addr_hit;

  assign addr_valid = hsel && hready && htrans[1];
  assign addr_hit   = (haddr[7:0] == OVERRIDE_OFFSET) && (haddr[31:8] == 24'h00_0000);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_hit_r  <= 1'b0;
      rd_hit_r  <= 1'b0;
    end
    else if (hready)
    begin
      wr_pend_r <= addr_valid && hwrite;
      wr_hit_r  <= addr_valid && hwrite && addr_hit;
      rd_hit_r  <= addr_valid && !hwrite && addr_hit;
    end
  end

  // zero wait states; every access answers OKAY, unmapped reads give zero
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [2:0]  trim_r;
  logic [2:0]  trim_nxt;
  logic        trim_init_r;
  wire  logic  reload_event;
  wire  logic [2:0] trim_default;
  wire  logic [2:0] trim_reload;

  // only the writable field bits are kept, so reserved positions stay zero
  assign ctrl_nxt = wr_hit_r ? (hwdata & WRITE_MASK) : ctrl_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ctrl_r <= OVERRIDE_RESET;
    else
      ctrl_r <= ctrl_nxt;
  end

  assign trim_default = trim_source.image_present ? trim_source.config_image_current_trim :
                        trim_source.otp_programmed ? trim_source.otp_current_trim :
                        TRIM_NOMINAL;

  // the reload deliberately skips otp: only the image or nominal
  assign trim_reload  = trim_source.image_present ? trim_source.config_image_current_trim :
                        TRIM_NOMINAL;

  assign reload_event = usb_reset || lite_reset;

  // the trim sits outside the usb and lite reset domain; the sources are
  // straps, so they are sampled by a clocked load after release
  assign trim_nxt = !trim_init_r ? trim_default :
                    reload_event ? trim_reload :
                    wr_hit_r ? hwdata[TRIM_LSB +: 3] :
                    trim_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      trim_r      <= TRIM_NOMINAL;
      trim_init_r <= 1'b0;
    end
    else
    begin
      trim_r      <= trim_nxt;
      trim_init_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  wire logic [31:0] read_word;

  assign read_word = (ctrl_r & ~(32'h0000_0700))
                   | ({29'h0000_0000, trim_r} << TRIM_LSB)
                   | ({31'h0000_0000, rx_sync_r} << FS_RX_BIT);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (addr_valid && !hwrite && addr_hit)
      hrdata <= read_word;
    else if (hready)
      hrdata <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // front end drive
  // ----------------------------------------------------------------
  wire logic [1:0] mask_field;
  wire logic       cs_on;

  assign mask_field = ctrl_r[TXVAL_LSB +: 2];
  // an invalid mask is flagged and treated as no valid bits
  assign hs_mask_invalid = (mask_field == MASK_INVALID);
  assign cs_on = ctrl_r[HS_CS_BIT] || hs_mode || ctrl_r[TXACT_BIT];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      frontend_ctrl <= '0;
    else
    begin
      frontend_ctrl.fs_driver_enable_n        <= ctrl_r[FS_OEN_BIT];
      frontend_ctrl.fs_positive_line_out      <= ctrl_r[FS_VP_BIT];
      frontend_ctrl.fs_negative_line_out      <= ctrl_r[FS_VM_BIT];
      frontend_ctrl.frontend_hs_tx_valid_bus  <= hs_mask_invalid ? MASK_NONE
                                                                 : mask_field;
      frontend_ctrl.hs_tx_bits                <= ctrl_r[TXDAT_LSB +: 2];
      frontend_ctrl.hs_current_source_on      <= cs_on;
      frontend_ctrl.hs_drive_current_trim     <= trim_r;
      frontend_ctrl.pullup_plus_line_on       <= ctrl_r[PU_DP_BIT];
      frontend_ctrl.pullup_minus_line_on      <= ctrl_r[PU_DM_BIT];
      frontend_ctrl.pulldown_plus_line_on     <= ctrl_r[PD_DP_BIT];
      frontend_ctrl.pulldown_minus_line_on    <= ctrl_r[PD_DM_BIT];
      frontend_ctrl.hs_driver_transmit_active <= ctrl_r[TXACT_BIT];
    end
  end

endmodule : usb_frontend_test_override

// >>> sim/ovr_chk_sva.sv
// checker: port relations of the test override register block
`timescale 1ns/1ps
module ovr_chk
  import frontend_test_pkg::*;
(
  input logic           hclk,
  input logic           hresetn,
  input logic           hsel,
  input logic [31:0]    haddr,
  input logic [1:0]     htrans,
  input logic           hwrite,
  input logic [31:0]    hwdata,
  input logic           hready,
  input logic [31:0]    hrdata,
  input logic           hs_mode,
  input logic           usb_reset,
  input logic           lite_reset,
  input trim_source_t   trim_source,
  input frontend_ctrl_t frontend_ctrl,
  input logic           hs_mask_invalid
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // ------------------------------------------------------------
  // a write reaches frontend_ctrl three edges after its address phase, hs_mask_invalid two
  // ------------------------------------------------------------
  sequence wr_s;
    hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_00C4;
  endsequence
  rsvd_zero_a: assert property ((hrdata & 32'hFF87_000D) == 32'h0)
    else $error("reserved read bits set");
  drv_en_a: assert property (wr_s |-> ##3
    frontend_ctrl.fs_driver_enable_n == $past(hwdata[22], 2)) else $error("driver enable");
  line_data_a: assert property (wr_s |-> ##3
    {frontend_ctrl.fs_positive_line_out, frontend_ctrl.fs_negative_line_out}
      == $past(hwdata[21:20], 2)) else $error("line data");
  tx_bits_a: assert property (wr_s |-> ##3
    frontend_ctrl.hs_tx_bits == $past(hwdata[13:12], 2)) else $error("tx bits");
  term_ctl_a: assert property (wr_s |-> ##3
    {frontend_ctrl.pullup_plus_line_on, frontend_ctrl.pullup_minus_line_on,
     frontend_ctrl.pulldown_plus_line_on, frontend_ctrl.pulldown_minus_line_on}
      == $past(hwdata[7:4], 2)) else $error("terminations");
  tx_act_a: assert property (wr_s |-> ##3
    frontend_ctrl.hs_driver_transmit_active == $past(hwdata[1], 2)) else $error("tx active");
  mask_flag_a: assert property (wr_s |-> ##2
    hs_mask_invalid == ($past(hwdata[15:14]) == 2'h2)) else $error("mask flag");
  mask_off_a: assert property ($past(hs_mask_invalid) |->
    frontend_ctrl.frontend_hs_tx_valid_bus == 2'h0) else $error("invalid mask drives");
  cs_hs_a: assert property (hs_mode ##1 hs_mode |->
    frontend_ctrl.hs_current_source_on) else $error("source off in hs");
  cs_act_a: assert property (frontend_ctrl.hs_driver_transmit_active |->
    frontend_ctrl.hs_current_source_on) else $error("source off when active");
  trim_load_a: assert property ((usb_reset || lite_reset) |-> ##2
    frontend_ctrl.hs_drive_current_trim == (trim_source.image_present ?
      trim_source.config_image_current_trim : 3'h0)) else $error("trim reload");
endmodule : ovr_chk

// >>> sim/tb_top.sv
// testbench: bus accesses and override output checks for the test override block
`timescale 1ns/1ps
module tb_top
  import frontend_test_pkg::*;
;
  logic           hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic           hs_mode = 1'b0, usb_reset = 1'b0, lite_reset = 1'b0, rx = 1'b0;
  logic           hready, hreadyout, hresp, hs_mask_invalid;
  logic [31:0]    haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]     htrans = 2'h0;
  logic [2:0]     hsize = 3'h2;
  trim_source_t   trim_source = '{1'b1, 3'h5, 1'b1, 3'h6};
  frontend_ctrl_t frontend_ctrl;
  int             n_errors = 0, check_count = 0, cyc = 0;

  always #4 hclk = ~hclk;
  assign hready = hreadyout;

  usb_frontend_test_override i_usb_frontend_test_override (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
    .fs_diff_receiver_in(rx), .hs_mode, .usb_reset, .lite_reset, .trim_source,
    .frontend_ctrl, .hs_mask_invalid);

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // ------------------------------------------------------------
  // bus master: single word transfers, waits on ready each phase
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rd);
    chk("response", 32'h0000_0000, 32'(hresp));
    chk("ready", 32'h0000_0001, 32'(hreadyout));
  endtask : rchk

  task automatic rst();
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask : rst

  // one cycle of usb reset (u high) or lite reset (u low)
  task automatic reload(input logic u);
    usb_reset  <= u;
    lite_reset <= !u;
    @(posedge hclk);
    usb_reset  <= 1'b0;
    lite_reset <= 1'b0;
  endtask : reload

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  initial
  begin
    rst();
    rchk("reset", 32'hC4, 32'h0000_0500);
    xfer(1'b1, 32'hC4, 32'hFFFF_FFFF);
    rchk("ones", 32'hC4, 32'h0070_FFF2);
    chk("drive", 32'h0000_FFFF, 32'(frontend_ctrl));
    xfer(1'b1, 32'hC4, 32'h0);
    hs_mode <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("source", 32'h1, 32'(frontend_ctrl.hs_current_source_on));
    hs_mode <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, 32'hC4, (32'(i) << 14) | (32'(i) << 8));
      rchk("mask trim", 32'hC4, (32'(i % 4) << 14) | (32'(i) << 8));
      chk("mask flag", 32'(i % 4 == 2), 32'(hs_mask_invalid));
      chk("valid bus", (i % 4 == 2) ? 32'h0 : 32'(i % 4),
          32'(frontend_ctrl.frontend_hs_tx_valid_bus));
      chk("trim out", 32'(i), 32'(frontend_ctrl.hs_drive_current_trim));
    end
    rx <= 1'b1;
    repeat (3) @(posedge hclk);
    rchk("receiver", 32'hC4, 32'h0008_C700);
    xfer(1'b1, 32'hC8, 32'hFFFF_FFFF);
    rchk("unmapped", 32'hC8, 32'h0);
    reload(1'b1);
    rchk("usb reload", 32'hC4, 32'h0008_C500);
    xfer(1'b1, 32'hC4, 32'h0000_0200);
    reload(1'b0);
    rchk("lite reload", 32'hC4, 32'h0008_0500);
    rx <= 1'b0;
    trim_source <= '{1'b0, 3'h5, 1'b1, 3'h6};
    rst();
    rchk("otp default", 32'hC4, 32'h0000_0600);
    reload(1'b0);
    rchk("no image", 32'hC4, 32'h0);
    report_and_stop();
  end
endmodule : tb_top

bind usb_frontend_test_override ovr_chk i_ovr_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hwdata, .hready, .hrdata, .hs_mode, .usb_reset, .lite_reset, .trim_source,
  .frontend_ctrl, .hs_mask_invalid);
